// [common/sfi_pkg.sv]
package sfi_pkg;
   // ==========================================
   // Command codes
   // One code both wakes from deep sleep and reads the signature
   localparam logic [7:0] CMD_UNLOCK = 8'h06, CMD_LOCK = 8'h04, CMD_STAT = 8'h05, CMD_WSTAT = 8'h01,
      CMD_ID = 8'h9F, CMD_WAKE_SIG = 8'hAB, CMD_MKDEV = 8'h90, CMD_SLEEP = 8'hB9,
      CMD_READ = 8'h03, CMD_FREAD = 8'h0B, CMD_DOREAD = 8'h3B, CMD_DIOREAD = 8'hBB,
      CMD_QOREAD = 8'h6B, CMD_QIOREAD = 8'hEB, CMD_PROG = 8'h02, CMD_SERASE = 8'h20,
      CMD_B32ERASE = 8'h52, CMD_B64ERASE = 8'hD8, CMD_CERASE = 8'h60, CMD_RSTARM = 8'h66,
      CMD_RST = 8'h99, CMD_SUSP = 8'hB0, CMD_RESUME = 8'h30, CMD_OTPIN = 8'hB1,
      CMD_OTPOUT = 8'hC1, CMD_SECRD = 8'h2B, CMD_SECWR = 8'h2F;
   // ==========================================
   // Framing, lanes and dummy cycles
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] ADDR_LAST = 3'h3;
   localparam logic [2:0] LW1 = 3'h1, LW2 = 3'h2, LW4 = 3'h4;
   localparam logic [1:0] DC_SIX = 2'h1, DC_EIGHT = 2'h2, DC_TEN = 2'h3;
   localparam logic [3:0] DUM_FOUR = 4'h4, DUM_SIX = 4'h6, DUM_EIGHT = 4'h8, DUM_TEN = 4'hA;
   // ==========================================
   // Array geometry and protection
   localparam int ARRAY_AW = 25;
   localparam int BLK_LSB = 16;
   localparam int BLK_W = 9;
   localparam logic [BLK_W:0] BLK_COUNT = 10'h200;
   localparam logic [3:0] LVL_ALL = 4'hA;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [31:0] OTP_BYTES = 32'h200;
   // Status byte: busy, latch, level, top/bottom
   localparam int ST_BUSY = 0, ST_LATCH = 1, ST_LVL = 2, ST_TB = 6;
   localparam int SEC_FACT = 0, SEC_CUST = 1;
   localparam int CFG_DC = 6;
   // ==========================================
   // Types
   typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_SKIP} sfi_phase_t;
   typedef enum logic [2:0] {OP_PROG, OP_SECT, OP_B32, OP_B64, OP_CHIP} sfi_op_t;
   typedef struct packed {
      sfi_op_t op;
      logic otp;
      logic [ARRAY_AW-1:0] addr;
   } sfi_req_t;
   typedef struct packed {
      sfi_phase_t ph;
      logic [7:0] cmd, sh, ob, wsb, wcb;
      logic [23:0] id;
      logic [3:0] bits, dcnt;
      logic [2:0] w, dw, acnt;
      logic [31:0] addr;
      logic [8:0] pcnt;
      logic ld, first;
   } sfi_xfer_t;
   typedef struct packed {
      logic write_latch_flag, busy, susp, dpd, tb, arm, otp, cust;
      logic [3:0] lvl;
      logic [1:0] dc;
   } sfi_stat_t;
endpackage : sfi_pkg

// [design/sfi_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Pins sampled on rising serial clock, modes 0 and 3 both work.
// - Single lane: clock, data in, data out; only while select is low.
// - Two-lane reads turn lanes zero and one bidirectional.
// - Four-lane reads add lanes two and three, bidirectional.
// - Data-changing commands must end on a byte boundary at select rise.
// - Program, erase and register writes need the write latch flag set.
// - In deep sleep only wake, signature and software reset are heard.
// - Reset returns the sequencer to standby; changes need complete commands.
// - Standby whenever select is high and nothing runs.
// - Accepted program or erase starts the array operation by itself.
// - Program one to 256 bytes; erase sector, 32K, 64K or chip.
// - Busy flag set while program or erase runs, readable by status read.
// - Dummy cycles selectable 6, 8, 10, or per-command defaults of 4, 6 or 8.
// - The ten-cycle dummy setting is refused except on the fast grade.
// - Level bits and top/bottom bit fence off program and erase.
// - Identification returns maker plus two device bytes, signature, maker-device.
// - 4K-bit one-time area with factory and customer locks.
// - Program/erase suspend, resume and command reset.
// - Outside four-lane use, lane two is write guard, lane three is reset.
// - Four-lane or quad-command use disables the hardware guard.
// ==========================================
// Program data buffer
module sfi_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic do_wr, do_rd;
   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem[rd_reg];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      if (do_wr) begin
         wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_rd) begin
         rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
      if (do_wr) begin
         mem[wr_reg] <= in_data;
      end
   end
endmodule : sfi_fifo
// ==========================================
// Serial command front end
module sfi_core #(
   parameter logic [7:0] MAKER_ID = 8'hA5,  // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h3C5A,  // Arbitrary value
   parameter bit HIGH_SPEED = 1'b0,
   parameter bit FACTORY_LOCKED = 1'b1,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Serial link pins
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic [3:0] IO_LANE_IN,
   output logic [3:0] IO_LANE_OUT,
   output logic [3:0] IO_LANE_OE_N,
   // Mode and status
   input wire logic QUAD_CMD_MODE,
   output logic BUSY_FLAG,
   output logic WRITE_LATCH_FLAG,
   output logic DEEP_SLEEP,
   output logic STANDBY,
   output logic SUSPEND_REQ,
   output logic OTP_MODE,
   output logic CMD_REJECT,
   output logic PROG_OVERRUN,
   // Array back end
   output sfi_pkg::sfi_req_t OP_REQ,
   output logic OP_START,
   input wire logic OP_DONE,
   output logic [sfi_pkg::ARRAY_AW-1:0] RD_ADDR,
   input wire logic [7:0] RD_DATA,
   output logic [7:0] PROG_DATA,
   output logic PROG_VALID,
   input wire logic PROG_READY
);
   import sfi_pkg::*;
   logic [5:0] s1_reg, s2_reg;
   logic sck_d_reg, cs_d_reg;
   sfi_xfer_t xr, xn;
   sfi_stat_t sr, sn;
   sfi_req_t req_reg, req_next;
   logic start_reg, start_next, rej_reg, rej_next, ovr_reg, ovr_next, stby_reg;
   logic [3:0] lo_reg, lo_next, loe_reg, loe_next;
   logic sck, cs_n, rise, fall, cs_rise, quad_act, guard, hw_rst, byte_done, push, fifo_rdy, hit, wr_ok;
   logic [3:0] lin, bn;
   logic [2:0] cw, wuse;
   logic [7:0] shn;
   logic [BLK_W:0] span, blk;
   // ==========================================
   // Pin synchronisers and edges
   // sample on rising serial clock
   always_ff @(posedge CLK) begin
      s1_reg <= {SCLK, CS_N, IO_LANE_IN};
      s2_reg <= s1_reg;
      sck_d_reg <= s2_reg[5];
      cs_d_reg <= s2_reg[4];
   end
   assign sck = s2_reg[5];
   assign cs_n = s2_reg[4];
   assign lin = s2_reg[3:0];
   // link active only with select low
   assign rise = sck && !sck_d_reg && !cs_n;
   assign fall = !sck && sck_d_reg && !cs_n;
   assign cs_rise = cs_n && !cs_d_reg;
   assign quad_act = QUAD_CMD_MODE || (xr.dw == LW4 && !cs_n);
   assign guard = !lin[2] && !quad_act;
   assign hw_rst = !lin[3] && !quad_act;
   assign cw = QUAD_CMD_MODE ? LW4 : LW1;
   assign wuse = (xr.ph == PH_CMD) ? cw : xr.w;
   assign bn = xr.bits + 4'(wuse);
   assign byte_done = bn == BYTE_BITS;
   always_comb begin
      case (wuse)
         LW4: shn = {xr.sh[3:0], lin};
         LW2: shn = {xr.sh[5:0], lin[1:0]};
         default: shn = {xr.sh[6:0], lin[0]};
      endcase
   end
   assign blk = {1'b0, xr.addr[BLK_LSB +: BLK_W]};
   assign span = {{BLK_W{1'b0}}, 1'b1} << (sr.lvl - 4'h1);
   always_comb begin
      if (sr.otp) begin
         // locked or outside the one-time area
         hit = FACTORY_LOCKED || sr.cust || xr.addr >= OTP_BYTES || xr.cmd != CMD_PROG;
      end else if (sr.lvl == '0) begin
         hit = 1'b0;
      end else if (sr.lvl >= LVL_ALL || xr.cmd == CMD_CERASE) begin
         hit = 1'b1;
      end else begin
         hit = sr.tb ? (blk < span) : (blk >= BLK_COUNT - span);
      end
   end
   assign wr_ok = sr.write_latch_flag && !sr.busy && !sr.susp;
   function automatic logic [3:0] dummy_for(input logic [7:0] c, input logic [1:0] dc);
      case (dc)
         DC_SIX: dummy_for = DUM_SIX;
         DC_EIGHT: dummy_for = DUM_EIGHT;
         DC_TEN: dummy_for = DUM_TEN;
         default: dummy_for = (c == CMD_DIOREAD) ? DUM_FOUR : (c == CMD_QIOREAD) ? DUM_SIX : DUM_EIGHT;
      endcase
   endfunction : dummy_for
   function automatic sfi_op_t op_of(input logic [7:0] c);
      case (c)
         CMD_PROG: op_of = OP_PROG;
         CMD_SERASE: op_of = OP_SECT;
         CMD_B32ERASE: op_of = OP_B32;
         CMD_B64ERASE: op_of = OP_B64;
         default: op_of = OP_CHIP;
      endcase
   endfunction : op_of
   // ==========================================
   // Sequencer next state
   always_comb begin
      xn = xr;
      sn = sr;
      req_next = req_reg;
      start_next = 1'b0;
      rej_next = 1'b0;
      ovr_next = ovr_reg;
      push = 1'b0;
      if (rise && xr.ph != PH_DOUT) begin
         xn.sh = shn;
         xn.bits = byte_done ? '0 : bn;
         case (xr.ph)
            PH_CMD: if (byte_done) begin
               // one command byte decides the frame
               xn.cmd = shn;
               xn.acnt = '0;
               xn.pcnt = '0;
               xn.dw = '0;
               xn.dcnt = dummy_for(shn, sr.dc);
               xn.w = cw;
               xn.ph = PH_ADDR;
               xn.id = (shn == CMD_ID) ? {MAKER_ID, DEVICE_ID} : (shn == CMD_WAKE_SIG) ?
                  {3{DEVICE_ID[7:0]}} : {MAKER_ID, DEVICE_ID[7:0], MAKER_ID};
               if (sr.dpd && shn != CMD_WAKE_SIG && shn != CMD_RSTARM && shn != CMD_RST) begin
                  xn.ph = PH_SKIP;
               end else begin
                  case (shn)
                     CMD_READ: begin
                        xn.dw = cw;
                        xn.dcnt = '0;
                     end
                     CMD_FREAD: xn.dw = cw;
                     CMD_DOREAD: xn.dw = QUAD_CMD_MODE ? LW4 : LW2;
                     CMD_DIOREAD: begin
                        xn.w = QUAD_CMD_MODE ? LW4 : LW2;
                        xn.dw = xn.w;
                     end
                     CMD_QOREAD: xn.dw = LW4;
                     CMD_QIOREAD: begin
                        xn.w = LW4;
                        xn.dw = LW4;
                     end
                     CMD_PROG, CMD_SERASE, CMD_B32ERASE, CMD_B64ERASE: ovr_next = 1'b0;
                     CMD_STAT, CMD_SECRD, CMD_ID, CMD_WAKE_SIG, CMD_MKDEV: begin
                        xn.ph = PH_DOUT;
                        xn.dw = cw;
                        xn.ld = 1'b1;
                        xn.first = 1'b1;
                     end
                     CMD_UNLOCK, CMD_LOCK, CMD_WSTAT, CMD_CERASE, CMD_SLEEP, CMD_RSTARM, CMD_RST,
                        CMD_SUSP, CMD_RESUME, CMD_OTPIN, CMD_OTPOUT, CMD_SECWR: xn.ph = PH_DIN;
                     default: xn.ph = PH_SKIP;
                  endcase
               end
            end
            PH_ADDR: if (byte_done) begin
               xn.addr = {xr.addr[23:0], shn};
               xn.acnt = xr.acnt + 1'b1;
               if (xr.acnt == ADDR_LAST) begin
                  if (xr.dw == '0) begin
                     xn.ph = PH_DIN;
                  end else if (xr.dcnt != '0) begin
                     xn.ph = PH_DUMMY;
                  end else begin
                     xn.ph = PH_DOUT;
                     xn.w = xr.dw;
                     xn.ld = 1'b1;
                     xn.first = 1'b1;
                  end
               end
            end
            PH_DUMMY: begin
               xn.bits = '0;
               xn.dcnt = xr.dcnt - 1'b1;
               if (xr.dcnt == 4'h1) begin
                  xn.ph = PH_DOUT;
                  xn.w = xr.dw;
                  xn.ld = 1'b1;
                  xn.first = 1'b1;
               end
            end
            PH_DIN: if (byte_done) begin
               // page buffer holds at most one page
               if (xr.pcnt != PAGE_BYTES) begin
                  xn.pcnt = xr.pcnt + 1'b1;
                  push = xr.cmd == CMD_PROG;
               end
               if (xr.pcnt == '0) begin
                  xn.wsb = shn;
               end
               if (xr.pcnt == 9'h001) begin
                  xn.wcb = shn;
               end
               if (push && !fifo_rdy) begin
                  ovr_next = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (fall && xr.ph == PH_DOUT) begin
         if (xr.first) begin
            xn.first = 1'b0;
         end else begin
            xn.ob = (xr.w == LW4) ? {xr.ob[3:0], 4'h0} : (xr.w == LW2) ? {xr.ob[5:0], 2'h0} : {xr.ob[6:0], 1'b0};
            xn.bits = byte_done ? '0 : bn;
            xn.ld = byte_done;
         end
      end
      if (xr.ld && xr.ph == PH_DOUT) begin
         xn.ld = 1'b0;
         case (xr.cmd)
            // busy reads as clear while suspended
            CMD_STAT: xn.ob = {1'b0, sr.tb, sr.lvl, sr.write_latch_flag, sr.busy && !sr.susp};
            CMD_SECRD: xn.ob = {6'h00, sr.cust, FACTORY_LOCKED};
            CMD_ID, CMD_WAKE_SIG, CMD_MKDEV: begin
               xn.ob = xr.id[23:16];
               xn.id = {xr.id[15:0], xr.id[23:16]};
            end
            default: begin
               xn.ob = RD_DATA;
               xn.addr = xr.addr + 1'b1;
            end
         endcase
      end
      if (cs_rise) begin
         xn.ph = PH_CMD;
         xn.bits = '0;
         xn.ld = 1'b0;
         xn.dw = '0;
         sn.arm = 1'b0;
         // execute only on a byte boundary
         if (xr.ph == PH_DIN && xr.bits == '0) begin
            case (xr.cmd)
               CMD_UNLOCK: sn.write_latch_flag = !sr.busy;
               CMD_LOCK: sn.write_latch_flag = 1'b0;
               CMD_PROG, CMD_SERASE, CMD_B32ERASE, CMD_B64ERASE, CMD_CERASE: begin
                  if (wr_ok && !hit && (xr.cmd == CMD_PROG ? (xr.pcnt != '0 && !ovr_reg) : xr.pcnt == '0)) begin
                     // hand the operation to the array
                     start_next = 1'b1;
                     sn.busy = 1'b1;
                     req_next.op = op_of(xr.cmd);
                     req_next.otp = sr.otp;
                     req_next.addr = xr.addr[ARRAY_AW-1:0];
                  end else begin
                     rej_next = 1'b1;
                  end
               end
               CMD_WSTAT: begin
                  if (wr_ok && !guard && xr.pcnt != '0) begin
                     sn.lvl = xr.wsb[ST_LVL +: 4];
                     sn.tb = xr.wsb[ST_TB];
                     sn.write_latch_flag = 1'b0;
                     // ten-cycle setting only on the fast grade
                     if (xr.pcnt != 9'h001 && (HIGH_SPEED || xr.wcb[CFG_DC +: 2] != DC_TEN)) begin
                        sn.dc = xr.wcb[CFG_DC +: 2];
                     end
                  end else begin
                     rej_next = 1'b1;
                  end
               end
               CMD_SLEEP: sn.dpd = !sr.busy;
               CMD_RSTARM: sn.arm = 1'b1;
               CMD_RST: if (sr.arm) begin
                  sn.write_latch_flag = 1'b0;
                  sn.dpd = 1'b0;
                  sn.susp = 1'b0;
                  sn.otp = 1'b0;
                  sn.dc = '0;
               end
               CMD_SUSP: sn.susp = sr.busy;
               CMD_RESUME: sn.susp = 1'b0;
               CMD_OTPIN: sn.otp = 1'b1;
               CMD_OTPOUT: sn.otp = 1'b0;
               CMD_SECWR: if (wr_ok) begin
                  sn.cust = 1'b1;
                  sn.write_latch_flag = 1'b0;
               end
               default: ;
            endcase
         end else if (xr.ph == PH_DIN || xr.ph == PH_ADDR) begin
            rej_next = 1'b1;
         end
         if (xr.cmd == CMD_WAKE_SIG && xr.ph != PH_SKIP) begin
            sn.dpd = 1'b0;
         end
      end
      if (OP_DONE && sr.busy) begin
         sn.busy = 1'b0;
         sn.write_latch_flag = 1'b0;
         sn.susp = 1'b0;
      end
      // reset pin clears the front end
      if (hw_rst) begin
         xn.ph = PH_CMD;
         xn.bits = '0;
         sn.write_latch_flag = 1'b0;
         sn.dpd = 1'b0;
         sn.susp = 1'b0;
         sn.otp = 1'b0;
      end
      lo_next = (xn.w == LW4) ? xn.ob[7:4] : (xn.w == LW2) ? {2'h0, xn.ob[7:6]} : {2'h0, xn.ob[7], 1'b0};
      // lanes drive low-enabled only in output phase
      loe_next = 4'hF;
      if (xn.ph == PH_DOUT && !cs_n) begin
         loe_next = (xn.w == LW4) ? 4'h0 : (xn.w == LW2) ? 4'hC : 4'hD;
      end
   end
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         xr <= '0;
         sr <= '0;
         req_reg <= '0;
         start_reg <= 1'b0;
         rej_reg <= 1'b0;
         ovr_reg <= 1'b0;
         stby_reg <= 1'b0;
         lo_reg <= '0;
         loe_reg <= 4'hF;
      end else begin
         xr <= xn;
         sr <= sn;
         req_reg <= req_next;
         start_reg <= start_next;
         rej_reg <= rej_next;
         ovr_reg <= ovr_next;
         // standby with select high and idle
         stby_reg <= cs_n && !sr.busy;
         lo_reg <= lo_next;
         loe_reg <= loe_next;
      end
   end
   sfi_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst_n(NRST),
      .in_valid(push),
      .in_ready(fifo_rdy),
      .in_data(xn.sh),
      .out_valid(PROG_VALID),
      .out_ready(PROG_READY),
      .out_data(PROG_DATA)
   );
   assign IO_LANE_OUT = lo_reg;
   assign IO_LANE_OE_N = loe_reg;
   assign BUSY_FLAG = sr.busy;
   assign WRITE_LATCH_FLAG = sr.write_latch_flag;
   assign DEEP_SLEEP = sr.dpd;
   assign STANDBY = stby_reg;
   assign SUSPEND_REQ = sr.susp;
   assign OTP_MODE = sr.otp;
   assign CMD_REJECT = rej_reg;
   assign PROG_OVERRUN = ovr_reg;
   assign OP_REQ = req_reg;
   assign OP_START = start_reg;
   assign RD_ADDR = xr.addr[ARRAY_AW-1:0];
   // ==========================================
   // Checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_start_latch_set: assert property (OP_START |-> $past(sr.write_latch_flag) && !$past(sr.busy))
      else $error("operation started without write latch");
   a_start_on_boundary: assert property (OP_START |-> $past(xr.bits) == '0 && $past(cs_rise))
      else $error("operation started off a byte boundary");
   a_busy_after_start: assert property (OP_START |-> BUSY_FLAG ##1 (BUSY_FLAG || $past(OP_DONE)))
      else $error("busy flag not raised by start");
   a_sleep_filter: assert property ((sr.dpd && rise && xr.ph == PH_CMD && byte_done && shn == CMD_UNLOCK
      && !hw_rst && !cs_rise) |=> xr.ph == PH_SKIP)
      else $error("command heard in deep sleep");
   a_standby_entry: assert property ((cs_n && !sr.busy) [*2] |-> STANDBY)
      else $error("standby not entered");
   a_dummy_guard: assert property (!HIGH_SPEED |-> sr.dc != DC_TEN)
      else $error("ten dummy cycles selected");
   a_protect_block: assert property (OP_START |-> !$past(hit))
      else $error("protected area changed");
   a_guard_levels: assert property ($changed(sr.lvl) |-> !$past(guard) && $past(sr.write_latch_flag))
      else $error("levels written under guard");
   a_quad_drive: assert property (!IO_LANE_OE_N[2] |-> xr.w == LW4 && xr.ph == PH_DOUT)
      else $error("lane two driven outside four-lane output");
   a_reset_idle: assert property (@(posedge CLK) disable iff (1'b0) !NRST |=> xr.ph == PH_CMD && !BUSY_FLAG)
      else $error("reset did not return to standby");
endmodule : sfi_core
`default_nettype wire

// [tb/sfi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side of the serial link, clock mode 0
module sfi_host (
   // Clock
   input wire logic CLK,
   // Link pins
   output logic SCLK,
   output logic CS_N,
   output logic [3:0] IO_LANE_IN,
   input wire logic [3:0] IO_LANE_OUT,
   input wire logic [3:0] IO_LANE_OE_N
);
   logic lane0;
   logic guard_n = 1'b1;
   logic restart_n = 1'b1;
   logic [63:0] rx;
   // guard and restart pins idle high, scenarios pull them low
   // A released lane shows the inverse, so stale data cannot pass
   assign IO_LANE_IN = {restart_n, guard_n, IO_LANE_OE_N[1] ^ IO_LANE_OUT[1], lane0};
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      lane0 = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #5;
   endtask : tick
   task automatic xfer(input logic [127:0] tx, input int n);
      tick(1);
      CS_N = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         lane0 = tx[i];
         tick(8);
         rx = {rx[62:0], IO_LANE_OUT[1]};
         SCLK = 1'b1;
         tick(8);
         SCLK = 1'b0;
      end
      CS_N = 1'b1;
      lane0 = ~lane0;
      tick(12);
   endtask : xfer
endmodule : sfi_host
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sfi_pkg::*;
   localparam logic [7:0] MK = 8'h5C;  // Arbitrary value
   localparam logic [15:0] DV = 16'h1E2D;  // Arbitrary value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic done = 1'b0;
   logic prdy = 1'b0;
   logic qmode = 1'b0;
   logic sclk, cs_n, busy, write_latch_flag, dsl, stby, rej, ovr, start, pvalid, susp, otp;
   logic [3:0] lin, lout, loe_n;
   logic [7:0] pdata;
   logic [ARRAY_AW-1:0] raddr;
   sfi_req_t req;
   int err_count = 0;
   int checked = 0;
   int nrej = 0;
   int nst = 0;
   logic [7:0] pq [$];
   sfi_core #(.MAKER_ID(MK), .DEVICE_ID(DV)) i_dut (
      .CLK(clk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .IO_LANE_IN(lin), .IO_LANE_OUT(lout),
      .IO_LANE_OE_N(loe_n), .QUAD_CMD_MODE(qmode), .BUSY_FLAG(busy), .WRITE_LATCH_FLAG(write_latch_flag),
      .DEEP_SLEEP(dsl), .STANDBY(stby), .SUSPEND_REQ(susp), .OTP_MODE(otp), .CMD_REJECT(rej),
      .PROG_OVERRUN(ovr), .OP_REQ(req), .OP_START(start), .OP_DONE(done), .RD_ADDR(raddr),
      .RD_DATA(raddr[7:0] ^ 8'h5A), .PROG_DATA(pdata), .PROG_VALID(pvalid), .PROG_READY(prdy));
   sfi_host i_host (.CLK(clk), .SCLK(sclk), .CS_N(cs_n), .IO_LANE_IN(lin), .IO_LANE_OUT(lout),
      .IO_LANE_OE_N(loe_n));
   always #25 clk = ~clk;
   // Pulses are counted so a late check still sees them
   always @(posedge clk) begin
      if (rej === 1'b1) nrej++;
      if (start === 1'b1) nst++;
      if (pvalid === 1'b1 && prdy) pq.push_back(pdata);
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic op_end;
      done = 1'b1;
      i_host.tick(1);
      done = 1'b0;
      i_host.tick(4);
   endtask : op_end
   task automatic t_reset;
      chk("busy", 0, busy);
      chk("wel", 0, write_latch_flag);
      chk("oe_n", 4'hF, loe_n);
      chk("standby", 1, stby);
      $display("test reset done");
   endtask : t_reset
   task automatic t_guard;
      i_host.xfer({CMD_SERASE, 32'h0}, 40);
      chk("no latch reject", 1, nrej);
      i_host.xfer(CMD_UNLOCK, 8);
      chk("wel", 1, write_latch_flag);
      i_host.xfer({CMD_SERASE, 33'h0}, 41);
      chk("odd length reject", 2, nrej);
      chk("no start", 0, nst);
      $display("test guard done");
   endtask : t_guard
   task automatic t_fifo;
      i_host.xfer(CMD_UNLOCK, 8);
      i_host.xfer({CMD_PROG, 32'h100, 72'h01_0203_0405_0607_0809}, 112);
      chk("overrun", 1, ovr);
      chk("overrun reject", 3, nrej);
      prdy = 1'b1;
      i_host.tick(20);
      chk("fifo count", 8, pq.size());
      for (int i = 0; i < 8; i++) chk("fifo byte", i + 1, pq[i]);
      $display("test fifo done");
   endtask : t_fifo
   task automatic t_prog;
      pq.delete();
      i_host.xfer(CMD_UNLOCK, 8);
      i_host.xfer({CMD_PROG, 32'h1234, 8'hC3}, 48);
      chk("overrun clear", 0, ovr);
      chk("start", 1, nst);
      chk("op", OP_PROG, req.op);
      chk("addr", 25'h1234, req.addr);
      chk("data", 8'hC3, pq[0]);
      chk("standby", 0, stby);
      i_host.xfer({CMD_STAT, 8'h0}, 16);
      chk("status", 8'h03, i_host.rx[7:0]);
      i_host.xfer(CMD_SUSP, 8);
      chk("suspend", 1, susp);
      i_host.xfer({CMD_STAT, 8'h0}, 16);
      chk("status suspended", 8'h02, i_host.rx[7:0]);
      i_host.xfer(CMD_RESUME, 8);
      chk("resume", 0, susp);
      op_end();
      chk("busy", 0, busy);
      $display("test program done");
   endtask : t_prog
   task automatic t_erase;
      logic [7:0] c [4] = '{CMD_SERASE, CMD_B32ERASE, CMD_B64ERASE, CMD_CERASE};
      sfi_op_t o [4] = '{OP_SECT, OP_B32, OP_B64, OP_CHIP};
      for (int i = 0; i < 4; i++) begin
         i_host.xfer(CMD_UNLOCK, 8);
         if (i == 3) i_host.xfer(c[i], 8);
         else i_host.xfer({c[i], 32'h20000}, 40);
         chk("erase start", i + 2, nst);
         chk("erase op", o[i], req.op);
         op_end();
         chk("wel after op", 0, write_latch_flag);
      end
      $display("test erase done");
   endtask : t_erase
   task automatic t_sleep;
      i_host.xfer(CMD_SLEEP, 8);
      chk("sleep", 1, dsl);
      i_host.xfer(CMD_UNLOCK, 8);
      chk("ignored unlock", 0, write_latch_flag);
      i_host.xfer(CMD_WAKE_SIG, 8);
      chk("wake", 0, dsl);
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_id;
      i_host.xfer({CMD_ID, 24'h0}, 32);
      chk("id", {MK, DV}, i_host.rx[23:0]);
      i_host.xfer({CMD_READ, 32'h123, 8'h0}, 48);
      chk("read", 8'h23 ^ 8'h5A, i_host.rx[7:0]);
      $display("test id done");
   endtask : t_id
   task automatic t_protect;
      i_host.guard_n = 1'b0;
      i_host.xfer(CMD_UNLOCK, 8);
      i_host.xfer({CMD_WSTAT, 16'h04C0}, 24);
      chk("guard reject", 4, nrej);
      i_host.guard_n = 1'b1;
      i_host.xfer({CMD_WSTAT, 16'h04C0}, 24);
      i_host.xfer({CMD_STAT, 8'h0}, 16);
      chk("level status", 8'h04, i_host.rx[7:0]);
      i_host.xfer({CMD_FREAD, 32'h45, 16'h0}, 56);
      chk("default dummy", 8'h45 ^ 8'h5A, i_host.rx[7:0]);
      i_host.xfer(CMD_UNLOCK, 8);
      i_host.xfer({CMD_B64ERASE, 32'h1FF0000}, 40);
      chk("protected reject", 5, nrej);
      chk("protected start", 5, nst);
      i_host.restart_n = 1'b0;
      i_host.tick(4);
      chk("restart wel", 0, write_latch_flag);
      i_host.restart_n = 1'b1;
      i_host.tick(4);
      i_host.xfer(CMD_OTPIN, 8);
      chk("otp mode", 1, otp);
      i_host.xfer({CMD_SECRD, 8'h0}, 16);
      chk("lock bits", 8'h01, i_host.rx[7:0]);
      i_host.xfer(CMD_OTPOUT, 8);
      chk("otp exit", 0, otp);
      $display("test protect done");
   endtask : t_protect
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      i_host.tick(5);
      nrst = 1'b1;
      i_host.tick(4);
      t_reset();
      t_guard();
      t_fifo();
      t_prog();
      t_erase();
      t_sleep();
      t_id();
      t_protect();
      end_sim();
   end
   // Runs are near 0.65 ms; three leaves margin
   initial begin
      #3ms;
      err_count++;
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
